// ==== hw/fuse_config_pkg.sv ====
// package: register map, fuse field layout and decode constants for the fuse decoder
package fuse_config_pkg;
    localparam int          fuse_count          = 32;
    localparam logic [31:0] fuse_shipped        = 32'hFFF7FFFF;
    localparam logic [31:0] fuse_erased         = 32'hFFFFFFFF;
    // register byte offsets
    localparam logic [7:0]  off_fuse_low        = 8'h10;
    localparam logic [7:0]  off_fuse_ctrl       = 8'h00;
    localparam logic [7:0]  off_status          = 8'h04;
    localparam logic [7:0]  off_serial_0        = 8'h20;
    localparam logic [7:0]  off_serial_3        = 8'h2C;
    localparam logic [7:0]  off_boot_cfg_0      = 8'h30;
    localparam logic [7:0]  off_boot_cfg_1      = 8'h34;
    // fuse field positions
    localparam int          pos_lock            = 0;
    localparam int          pos_priv_fetch      = 16;
    localparam int          pos_boot_prot       = 17;
    localparam int          pos_level           = 20;
    localparam int          pos_hyst            = 26;
    localparam int          pos_enable          = 27;
    localparam int          pos_reserved        = 29;
    // brownout enable codes
    localparam logic [1:0]  bod_off_0           = 2'h0;
    localparam logic [1:0]  bod_with_reset      = 2'h1;
    localparam logic [1:0]  bod_no_reset        = 2'h2;
    localparam logic [1:0]  bod_off_3           = 2'h3;
    localparam logic [5:0]  level_lowest        = 6'h3F;
    localparam logic [2:0]  boot_prot_8k        = 3'h3;
    localparam logic [1:0]  resp_okay           = 2'h0;
    localparam logic [1:0]  resp_slverr         = 2'h2;
    // control register bits
    localparam int          ctrl_chip_erase     = 0;
    localparam logic [7:0]  ctrl_key            = 8'hA5;
    localparam int          ctrl_key_pos        = 8;

    typedef struct packed {
        logic       brownout_enable;
        logic       brownout_reset_enable;
        logic       brownout_hysteresis;
        logic [5:0] brownout_trigger_level;
        logic [2:0] boot_protect_size;
        logic       priv_fetch_unlocked;
        logic [15:0] region_locked;
    } fuse_decode_t;
endpackage : fuse_config_pkg

// ==== hw/fuse_config_decode.sv ====
// fuse holding register, field decoder and axi4-lite register slave
//
// Decided for this implementation: the address map and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none

// Operation
// - thirty-two fuse bits readable in fuse low register
// - test-port chip erase sets every fuse bit
// - enable field: 1 reset, 2 no-reset, else off
// - hysteresis fuse one enables detector hysteresis
// - six-bit level passed through; all ones lowest
// - reset-enabled detector above supply holds reset
// - shipped pattern FFF7FFFF, bit nineteen cleared
// - boot code 011 protects eight kilobytes
// - privileged fetch fuse one leaves fetch unlocked
// - lock fuse one leaves its region unlocked
// - bits 31 to 29 reserved but readable
// - 120-bit serial number readable from factory page
// - two bootloader words held in user page
// - programmed fuse reads zero, erased reads one
module fuse_config_decode #(
    parameter logic [119:0] serial_number = 120'h0,        // arbitrary value
    parameter logic [31:0]  boot_word_0   = 32'hFFFFFFFF,  // arbitrary value
    parameter logic [31:0]  boot_word_1   = 32'hFFFFFFFF   // arbitrary value
) (
    input  wire logic                          clock,
    input  wire logic                          reset,
    input  wire logic [31:0]                   fuse_array,
    input  wire logic                          test_chip_erase,
    input  wire logic                          level_above_supply,
    output logic                               hold_in_reset,
    output fuse_config_pkg::fuse_decode_t      decode,
    output logic [12:0]                        boot_protect_bytes,
    input  wire logic [7:0]                    s_axi_awaddr,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [31:0]                   s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    output logic [1:0]                         s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    input  wire logic [7:0]                    s_axi_araddr,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    output logic [31:0]                        s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready
);
    // two-flop synchronisers for pin-level inputs; first stage read only by second
    logic [31:0] fuse_meta_reg,  fuse_sync_reg;
    logic        erase_meta_reg, erase_sync_reg;
    logic        above_meta_reg, above_sync_reg;

    always_ff @(posedge clock) begin
        fuse_meta_reg  <= fuse_array;
        fuse_sync_reg  <= fuse_meta_reg;
        erase_meta_reg <= test_chip_erase;
        erase_sync_reg <= erase_meta_reg;
        above_meta_reg <= level_above_supply;
        above_sync_reg <= above_meta_reg;
    end

    // fuse image and decoded fields
    logic [31:0]                   fuse_reg,   fuse_next;
    fuse_config_pkg::fuse_decode_t decode_reg, decode_next;
    logic                          sw_erase;

    always_comb begin
        fuse_next = fuse_reg;
        if (reset) begin
            fuse_next = fuse_sync_reg;
        end else if (erase_sync_reg || sw_erase) begin
            fuse_next = fuse_config_pkg::fuse_erased;
        end
    end

    // decode tracks the image; only changes after reset come from an erase
    always_comb begin
        logic [1:0] en;
        en = fuse_reg[fuse_config_pkg::pos_enable +: 2];
        case (en)
            fuse_config_pkg::bod_with_reset: begin
                decode_next.brownout_enable       = 1'b1;
                decode_next.brownout_reset_enable = 1'b1;
            end
            fuse_config_pkg::bod_no_reset: begin
                decode_next.brownout_enable       = 1'b1;
                decode_next.brownout_reset_enable = 1'b0;
            end
            default: begin
                decode_next.brownout_enable       = 1'b0;
                decode_next.brownout_reset_enable = 1'b0;
            end
        endcase
        decode_next.brownout_hysteresis    = fuse_reg[fuse_config_pkg::pos_hyst];
        decode_next.brownout_trigger_level = fuse_reg[fuse_config_pkg::pos_level +: 6];
        decode_next.boot_protect_size      = fuse_reg[fuse_config_pkg::pos_boot_prot +: 3];
        decode_next.priv_fetch_unlocked    = fuse_reg[fuse_config_pkg::pos_priv_fetch];
        decode_next.region_locked          = ~fuse_reg[fuse_config_pkg::pos_lock +: 16];
    end

    always_ff @(posedge clock) begin
        fuse_reg   <= fuse_next;
        decode_reg <= decode_next;
    end

    assign decode = decode_reg;
    // all-ones level is below any supply, so it never asserts above_supply
    assign hold_in_reset = decode_reg.brownout_reset_enable && above_sync_reg;

    // protected size: 2^(6-code) kB for codes 0 to 6 (011 gives 8 kB), code 111 gives 0; a shift keeps it one line
    always_comb begin
        boot_protect_bytes = 13'h0000;
        if (decode_reg.boot_protect_size != 3'h7) begin
            boot_protect_bytes = 13'(13'h0040 >> decode_reg.boot_protect_size);
        end
    end

    // axi4-lite write channel: address and data taken in either order
    logic       aw_held_reg, aw_held_next;
    logic       w_held_reg,  w_held_next;
    logic [7:0] aw_addr_reg, aw_addr_next;
    logic [31:0] w_data_reg, w_data_next;
    logic [3:0] w_strb_reg,  w_strb_next;
    logic       bvalid_reg,  bvalid_next;
    logic [1:0] bresp_reg,   bresp_next;
    logic       wr_fire;

    assign s_axi_awready = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready  = !w_held_reg && !bvalid_reg;
    assign wr_fire       = aw_held_reg && w_held_reg && !bvalid_reg;
    // erase command needs the key, stops a stray write from wiping the fuses
    assign sw_erase = wr_fire && (aw_addr_reg == fuse_config_pkg::off_fuse_ctrl)
        && w_strb_reg[0] && w_strb_reg[1] && w_data_reg[fuse_config_pkg::ctrl_chip_erase]
        && (w_data_reg[fuse_config_pkg::ctrl_key_pos +: 8] == fuse_config_pkg::ctrl_key);

    always_comb begin
        aw_held_next = aw_held_reg;
        w_held_next  = w_held_reg;
        aw_addr_next = aw_addr_reg;
        w_data_next  = w_data_reg;
        w_strb_next  = w_strb_reg;
        bvalid_next  = bvalid_reg;
        bresp_next   = bresp_reg;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_held_next = 1'b1;
            aw_addr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_held_next = 1'b1;
            w_data_next = s_axi_wdata;
            w_strb_next = s_axi_wstrb;
        end
        if (wr_fire) begin
            aw_held_next = 1'b0;
            w_held_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = (aw_addr_reg == fuse_config_pkg::off_fuse_ctrl)
                         ? fuse_config_pkg::resp_okay : fuse_config_pkg::resp_slverr;
        end else if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
        if (reset) begin
            aw_held_next = 1'b0;
            w_held_next  = 1'b0;
            aw_addr_next = 8'h00;
            w_data_next  = 32'h00000000;
            w_strb_next  = 4'h0;
            bvalid_next  = 1'b0;
            bresp_next   = fuse_config_pkg::resp_okay;
        end
    end

    always_ff @(posedge clock) begin
        aw_held_reg <= aw_held_next;
        w_held_reg  <= w_held_next;
        aw_addr_reg <= aw_addr_next;
        w_data_reg  <= w_data_next;
        w_strb_reg  <= w_strb_next;
        bvalid_reg  <= bvalid_next;
        bresp_reg   <= bresp_next;
    end

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp  = bresp_reg;

    // axi4-lite read channel
    logic        rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg,  rdata_next;
    logic [1:0]  rresp_reg,  rresp_next;
    logic [31:0] status_word;

    assign s_axi_arready = !rvalid_reg;
    assign status_word   = {26'h0000000, hold_in_reset, decode_reg.priv_fetch_unlocked,
                            decode_reg.brownout_hysteresis, decode_reg.brownout_reset_enable,
                            decode_reg.brownout_enable, above_sync_reg};

    always_comb begin
        rvalid_next = rvalid_reg;
        rdata_next  = rdata_reg;
        rresp_next  = rresp_reg;
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_next = 1'b1;
            rresp_next  = fuse_config_pkg::resp_okay;
            case (s_axi_araddr)
                // reserved bits 31..29 read back raw; erased fuse reads one
                fuse_config_pkg::off_fuse_low:   rdata_next = fuse_reg;
                fuse_config_pkg::off_status:     rdata_next = status_word;
                fuse_config_pkg::off_fuse_ctrl:  rdata_next = 32'h00000000;
                fuse_config_pkg::off_serial_0:   rdata_next = serial_number[31:0];
                8'h24:                           rdata_next = serial_number[63:32];
                8'h28:                           rdata_next = serial_number[95:64];
                fuse_config_pkg::off_serial_3:   rdata_next = {8'h00, serial_number[119:96]};
                fuse_config_pkg::off_boot_cfg_0: rdata_next = boot_word_0;
                fuse_config_pkg::off_boot_cfg_1: rdata_next = boot_word_1;
                default: begin
                    rdata_next = 32'h00000000;
                    rresp_next = fuse_config_pkg::resp_slverr;
                end
            endcase
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
        if (reset) begin
            rvalid_next = 1'b0;
            rdata_next  = 32'h00000000;
            rresp_next  = fuse_config_pkg::resp_okay;
        end
    end

    always_ff @(posedge clock) begin
        rvalid_reg <= rvalid_next;
        rdata_reg  <= rdata_next;
        rresp_reg  <= rresp_next;
    end

    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata  = rdata_reg;
    assign s_axi_rresp  = rresp_reg;
endmodule : fuse_config_decode

`default_nettype wire

// ==== tb/fuse_config_decode_sva.sv ====
// checker: timing and decode relations at the fuse decoder ports
`timescale 1ns/100ps
`default_nettype none
module fuse_config_sva (
    input wire logic                          clock,
    input wire logic                          reset,
    input wire logic                          test_chip_erase,
    input wire logic                          level_above_supply,
    input wire logic                          hold_in_reset,
    input wire logic                          s_axi_arvalid,
    input wire logic                          s_axi_arready,
    input wire logic                          s_axi_rvalid,
    input wire logic                          s_axi_rready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [12:0] boot_protect_bytes,
    input wire fuse_config_pkg::fuse_decode_t decode
);
    logic [7:0] last_ar;
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    // remembers which word the pending read returns
    always_ff @(posedge clock) if (s_axi_arvalid && s_axi_arready) last_ar <= s_axi_araddr;
    property p_fields;
        s_axi_rvalid && last_ar == 8'h10 |-> decode == {s_axi_rdata[28:27] == 2'h1
            || s_axi_rdata[28:27] == 2'h2, s_axi_rdata[28:27] == 2'h1, s_axi_rdata[26:16],
            ~s_axi_rdata[15:0]};
    endproperty
    a_fields: assert property (p_fields) else $error("decode differs from fuse word");
    property p_erase; test_chip_erase [*6] |-> decode == 29'h07FF0000; endproperty
    a_erase: assert property (p_erase) else $error("erase left decode");
    property p_boot; decode.boot_protect_size == 3'h3 |-> boot_protect_bytes == 13'h0008; endproperty
    a_boot: assert property (p_boot) else $error("boot size wrong");
    property p_hold_on; (decode.brownout_reset_enable && level_above_supply) [*5]
        |-> hold_in_reset; endproperty
    a_hold_on: assert property (p_hold_on) else $error("reset hold missing");
    property p_hold_off; !level_above_supply [*5] |-> !hold_in_reset; endproperty
    a_hold_off: assert property (p_hold_off) else $error("reset hold spurious");
    // only an erase may move the decode once reset has gone
    property p_frozen; !$past(reset) && !$past(reset, 2) && !$stable(decode)
        |-> decode == 29'h07FF0000; endproperty
    a_frozen: assert property (p_frozen) else $error("decode moved");
    property p_r_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_r_answer: assert property (p_r_answer) else $error("read answer late");
    property p_r_release; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
    a_r_release: assert property (p_r_release) else $error("read answer stuck");
endmodule : fuse_config_sva
bind fuse_config_decode fuse_config_sva chk_i (.*);
`default_nettype wire

// ==== tb/fuse_far_model.sv ====
// model: fuse cells and brown-out comparator on the far side
`timescale 1ns/100ps
`default_nettype none
module fuse_far_model #(parameter logic [5:0] supply_code = 6'h10) (
    input wire logic [31:0] burnt,
    input wire fuse_config_pkg::fuse_decode_t decode,
    output logic [31:0] fuse_array,
    output logic level_above_supply
);
    assign fuse_array = ~burnt;
    // lower code means higher trip voltage; a disabled detector reports nothing
    assign level_above_supply = decode.brownout_enable
        && (decode.brownout_trigger_level < supply_code);
endmodule : fuse_far_model
`default_nettype wire

// ==== tb/testbench.sv ====
// testbench: bus reads, erase paths and decode of the fuse decoder
`timescale 1ns/100ps
`default_nettype none
module testbench;
    localparam logic [119:0] sn = 120'h0123456789ABCDEF0123456789ABCD; // arbitrary value
    localparam logic [191:0] rom = {32'h2468ACE0, 32'h13579BDF, 8'h00, sn};
    logic clock = 1'h0;
    logic reset, test_chip_erase, level_above_supply, hold_in_reset, s_axi_awvalid, s_axi_awready;
    logic s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] burnt, fuse_array, s_axi_wdata, s_axi_rdata, rd, w;
    logic [12:0] boot_protect_bytes;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    fuse_config_pkg::fuse_decode_t decode;
    int miscompares = 0;
    int comparisons = 0;
    fuse_config_decode #(.serial_number(sn), .boot_word_0(32'h13579BDF), .boot_word_1(32'h2468ACE0))
        dut (.*);
    fuse_far_model far (.burnt, .decode, .fuse_array, .level_above_supply);
    initial forever #2 clock = ~clock;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        miscompares += int'(got !== exp);
        if (got !== exp) $display("[ERR] %0t got %h expected %h", $time, got, exp);
    endtask : chk
    task automatic summarize;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : summarize
    // one write or one read; control writes use the two low strobes only
    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
        s_axi_wstrb <= (a == 8'h00) ? 4'h3 : 4'hF;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= {we, we, we, !we, !we};
        do begin
            @(posedge clock);
            n++;
            {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= {s_axi_awvalid && !s_axi_awready,
                s_axi_wvalid && !s_axi_wready, s_axi_arvalid && !s_axi_arready};
        end while (!(we ? s_axi_bvalid : s_axi_rvalid) && n < 40);
        {s_axi_bready, s_axi_rready} <= 2'h0;
        rd = s_axi_rdata;
        rs = we ? s_axi_bresp : s_axi_rresp;
        miscompares += int'(n >= 40);
        if (n >= 40) summarize();
    endtask : bus
    task automatic boot(input logic [31:0] x);
        @(posedge clock);
        burnt <= ~x;
        reset <= 1'h1;
        repeat (12) @(posedge clock);
        reset <= 1'h0;
        repeat (6) @(posedge clock);
    endtask : boot
    // read first so a just-finished erase has reached the decode
    task automatic dec(input logic [31:0] x);
        bus(1'h0, 8'h10, 32'h00000000);
        chk(rd, x);
        chk(32'(decode), {3'h0, x[28:27] == 2'h1 || x[28:27] == 2'h2, x[28:27] == 2'h1,
            x[26:16], ~x[15:0]});
        chk(32'(hold_in_reset), 32'(x[28:27] == 2'h1 && x[25:20] < 6'h10));
        chk(32'(boot_protect_bytes), 32'(13'h0040 >> x[19:17]));
        bus(1'h0, 8'h04, 32'h00000000);
        chk(rd, {26'h0000000, x[28:27] == 2'h1 && x[25:20] < 6'h10, x[16], x[26],
            x[28:27] == 2'h1, x[28] ^ x[27], (x[28] ^ x[27]) && x[25:20] < 6'h10});
    endtask : dec
    initial begin
        {reset, test_chip_erase, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 5'h10;
        {s_axi_bready, s_axi_rready, burnt, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        boot(32'hFFF7FFFF);
        dec(32'hFFF7FFFF);
        for (int c = 0; c < 4; c++) begin
            w = {3'h2, 2'(c), 1'h0, 6'h05, 3'h6, 1'h0, 16'h5AA5 ^ 16'(c)};
            boot(w);
            dec(w);
        end
        $display("decode test done");
        burnt <= 32'h00000000;
        bus(1'h1, 8'h10, 32'h00000000);
        chk(32'(rs), 32'h00000002);
        bus(1'h1, 8'h00, 32'h00005A01);
        dec(w);
        bus(1'h1, 8'h00, 32'h0000A501);
        dec(32'hFFFFFFFF);
        boot(w);
        test_chip_erase <= 1'h1;
        repeat (8) @(posedge clock);
        test_chip_erase <= 1'h0;
        dec(32'hFFFFFFFF);
        $display("erase test done");
        for (int i = 0; i < 6; i++) begin
            bus(1'h0, 8'h20 + 8'(4 * i), 32'h00000000);
            chk(rd, rom[32 * i +: 32]);
        end
        bus(1'h0, 8'h08, 32'h00000000);
        chk(32'(rs), 32'h00000002);
        $display("read test done");
        summarize();
    end
endmodule : testbench
`default_nettype wire
